// file: src/aiss_top.sv
`timescale 1ns/1ps
// Summary of operation
// - reset selects fast rate, converts once
// - after conversion sleep until addressed
// - result held unchanged while sleeping
// - nak own address during conversion
// - respond to address 0010100, and to 1110111 for writes only
// - eighth bit: one read, zero write
// - ack address after conversion done
// - shift result msb first on falling
// - write accepts one byte on rising
// - bit eight selects slow rate
// - restart on stop after an acknowledged address, or on full read
// - power-on hold clears, then converts
// - slow rate calibrates, conversion twice as long
// - clamp code to 0 and 65535
// - sda only pulled low or released
// - repeated start restarts address reception
// - nine clocks per address or write byte, ack ninth; read shifts 16 bits with no ack
// - sda changes only while scl low
// - write, repeated start, read keeps result
// - read returns latest conversion only
// - acknowledge global write, stop restarts
module aiss_top
   import aiss_pkg::*;
#(
   parameter int POR_CYCLES = AISS_POR_CYCLES,
   parameter int CONV60_CYCLES = AISS_CONV60_CYCLES,
   parameter int CONV30_CYCLES = AISS_CONV30_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // i2c pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // modulator samples
   input wire aiss_sample_t sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   // status
   output logic [1:0] mode,
   output logic slow_rate_select,
   output logic calib_active
);
   // ==========================================
   // pin synchronisers
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic scl_d_ff;
   logic sda_d_ff;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff <= 1'h1;
         sda_d_ff <= 1'h1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_in};
         sda_sync_ff <= {sda_sync_ff[0], sda_in};
         scl_d_ff <= scl_sync_ff[1];
         sda_d_ff <= sda_sync_ff[1];
      end
   end

   assign scl_rise = scl_sync_ff[1] && !scl_d_ff;
   assign scl_fall = !scl_sync_ff[1] && scl_d_ff;
   // start and stop only with scl high; data moves while scl low
   assign bus_start = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1];
   assign bus_stop = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1];

   // ==========================================
   // power-on hold
   logic [31:0] por_cnt_ff;
   logic por_busy_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         por_cnt_ff <= '0;
         por_busy_ff <= 1'h1;
      end else if (por_busy_ff) begin
         por_cnt_ff <= por_cnt_ff + 32'h1;
         if (por_cnt_ff >= 32'(POR_CYCLES - 1)) begin
            por_busy_ff <= 1'h0;
         end
      end
   end

   // ==========================================
   // converter sequencing
   aiss_mode_t mode_ff;
   aiss_bus_t bus_ff;
   logic [31:0] conv_cnt_ff;
   logic rate_ff;
   logic rate_pend_ff;
   logic rate_wr_ff;
   logic [15:0] result_ff;
   logic [15:0] last_code_ff;
   logic restart;
   logic conv_done;
   logic full_read;
   logic valid_xfer_ff;
   logic [31:0] conv_len;

   // fast rate after reset
   assign conv_len = rate_ff ? 32'(CONV30_CYCLES) : 32'(CONV60_CYCLES);
   assign conv_done = (mode_ff == AISS_CONVERT) && !por_busy_ff && (conv_cnt_ff >= conv_len - 32'h1);
   assign restart = (bus_stop && valid_xfer_ff) || full_read;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_ff <= AISS_CONVERT;
      end else begin
         unique case (mode_ff)
            AISS_CONVERT: begin
               if (conv_done) begin
                  mode_ff <= AISS_SLEEP;
               end
            end
            AISS_SLEEP: begin
               if (valid_xfer_ff) begin
                  mode_ff <= AISS_IO;
               end
            end
            AISS_IO: begin
               if (restart) begin
                  mode_ff <= AISS_CONVERT;
               end else if (bus_stop) begin
                  mode_ff <= AISS_SLEEP;
               end
            end
            default: begin
               mode_ff <= AISS_CONVERT;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_cnt_ff <= '0;
      end else if (mode_ff != AISS_CONVERT || por_busy_ff) begin
         conv_cnt_ff <= '0;
      end else begin
         conv_cnt_ff <= conv_cnt_ff + 32'h1;
      end
   end

   // rate written takes effect only at restart
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_ff <= AISS_RATE_RESET;
      end else if (restart && rate_wr_ff) begin
         rate_ff <= rate_pend_ff;
      end
   end

   // ==========================================
   // modulator samples through the fifo
   aiss_sample_t fifo_data;
   logic fifo_valid;
   logic fifo_ready;

   aiss_fifo #(
      .WIDTH($bits(aiss_sample_t)),
      .DEPTH(16)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(sample_data),
      .in_valid(sample_valid),
      .in_ready(fifo_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(mode_ff == AISS_CONVERT)
   );

   // draining stalls outside conversion, so the source sees back-pressure
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sample_ready <= 1'h0;
      end else begin
         sample_ready <= fifo_ready;
      end
   end

   // latest sample during conversion wins; clamp on range flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_code_ff <= '0;
      end else if (mode_ff == AISS_CONVERT && fifo_valid) begin
         if (fifo_data.under) begin
            last_code_ff <= AISS_CODE_MIN;
         end else if (fifo_data.over) begin
            last_code_ff <= AISS_CODE_MAX;
         end else begin
            last_code_ff <= fifo_data.code;
         end
      end
   end

   // ==========================================
   // i2c slave
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic rd_ff;
   logic byte_cnt_ff;
   logic [4:0] tx_cnt_ff;
   logic ack_read;
   logic addr_ok;
   logic [6:0] rx_addr;

   // address sits in the upper seven bits once the direction bit has shifted in
   assign rx_addr = shift_ff[7:1];
   assign addr_ok = (mode_ff != AISS_CONVERT) &&
                    ((rx_addr == AISS_DEV_ADDR) ||
                     (rx_addr == AISS_GLOBAL_ADDR && !shift_ff[0]));
   assign full_read = (bus_ff == AISS_B_TX) && scl_fall && tx_cnt_ff == 5'(AISS_RESULT_BITS - 1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_ff <= AISS_B_IDLE;
         bit_cnt_ff <= '0;
         shift_ff <= '0;
         rd_ff <= 1'h0;
         valid_xfer_ff <= 1'h0;
         tx_cnt_ff <= '0;
         byte_cnt_ff <= 1'h0;
         rate_pend_ff <= AISS_RATE_RESET;
         rate_wr_ff <= 1'h0;
         result_ff <= '0;
      end else begin
         if (conv_done) begin
            result_ff <= last_code_ff;
         end
         if (restart || bus_stop) begin
            valid_xfer_ff <= 1'h0;
            rate_wr_ff <= 1'h0;
         end
         if (bus_start) begin
            bus_ff <= AISS_B_ADDR;
            bit_cnt_ff <= '0;
         end else if (bus_stop) begin
            bus_ff <= AISS_B_IDLE;
         end else begin
            unique case (bus_ff)
               AISS_B_IDLE, AISS_B_IGNORE: begin
               end
               AISS_B_ADDR: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                     rd_ff <= shift_ff[0];
                     if (addr_ok) begin
                        bus_ff <= AISS_B_ACK;
                        valid_xfer_ff <= 1'h1;
                     end else begin
                        bus_ff <= AISS_B_IGNORE;
                     end
                  end
               end
               AISS_B_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= '0;
                     tx_cnt_ff <= '0;
                     byte_cnt_ff <= 1'h0;
                     bus_ff <= rd_ff ? AISS_B_TX : AISS_B_RX;
                  end
               end
               AISS_B_TX: begin
                  if (scl_fall) begin
                     tx_cnt_ff <= tx_cnt_ff + 5'h1;
                     if (full_read) begin
                        bus_ff <= AISS_B_IGNORE;
                     end
                  end
               end
               AISS_B_RX: begin
                  if (scl_rise) begin
                     shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                     if (!byte_cnt_ff) begin
                        rate_pend_ff <= shift_ff[AISS_RATE_BIT];
                        rate_wr_ff <= 1'h1;
                        byte_cnt_ff <= 1'h1;
                        bus_ff <= AISS_B_RXACK;
                     end else begin
                        bus_ff <= AISS_B_IGNORE;
                     end
                  end
               end
               AISS_B_RXACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= '0;
                     bus_ff <= AISS_B_RX;
                  end
               end
               default: begin
                  bus_ff <= AISS_B_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================
   // sda drive: pull low or release, never high
   logic nxt_sda_low;
   logic [3:0] tx_idx;

   assign tx_idx = 4'(AISS_RESULT_BITS - 1) - tx_cnt_ff[3:0];

   always_comb begin
      nxt_sda_low = 1'h0;
      unique case (bus_ff)
         AISS_B_ACK, AISS_B_RXACK: nxt_sda_low = 1'h1;
         AISS_B_TX: nxt_sda_low = !result_ff[tx_idx];
         default: nxt_sda_low = 1'h0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_oe <= 1'h0;
         sda_out <= 1'h0;
         mode <= AISS_CONVERT;
         slow_rate_select <= 1'h0;
         calib_active <= 1'h0;
      end else begin
         sda_oe <= nxt_sda_low && !bus_start && !bus_stop;
         sda_out <= 1'h0;
         mode <= mode_ff;
         slow_rate_select <= rate_ff;
         // calibration runs inside the same conversion window
         calib_active <= rate_ff && mode_ff == AISS_CONVERT && !por_busy_ff;
      end
   end
endmodule

// file: src/aiss_pkg.sv
package aiss_pkg;
   // ==========================================
   // bus addressing
   localparam logic [6:0] AISS_DEV_ADDR = 7'h14;
   localparam logic [6:0] AISS_GLOBAL_ADDR = 7'h77;
   localparam int AISS_RATE_BIT = 0;
   localparam logic AISS_RATE_RESET = 1'h0;
   localparam int AISS_RESULT_BITS = 16;
   // ==========================================
   // timing
   localparam int AISS_CLK_MHZ = 125;
   localparam int AISS_POR_US = 500;
   localparam int AISS_POR_CYCLES = AISS_POR_US * AISS_CLK_MHZ;
   localparam int AISS_CONV60_US = 16600;
   localparam int AISS_CONV30_US = 33200;
   localparam int AISS_CONV60_CYCLES = AISS_CONV60_US * AISS_CLK_MHZ;
   localparam int AISS_CONV30_CYCLES = AISS_CONV30_US * AISS_CLK_MHZ;
   localparam logic [15:0] AISS_CODE_MAX = 16'hffff;
   localparam logic [15:0] AISS_CODE_MIN = 16'h0000;

   typedef enum logic [1:0] {
      AISS_CONVERT = 2'b00,
      AISS_SLEEP = 2'b01,
      AISS_IO = 2'b10
   } aiss_mode_t;

   typedef enum logic [2:0] {
      AISS_B_IDLE = 3'b000,
      AISS_B_ADDR = 3'b001,
      AISS_B_ACK = 3'b010,
      AISS_B_TX = 3'b011,
      AISS_B_RX = 3'b100,
      AISS_B_RXACK = 3'b101,
      AISS_B_IGNORE = 3'b110
   } aiss_bus_t;

   typedef struct packed {
      logic over;
      logic under;
      logic [15:0] code;
   } aiss_sample_t;
endpackage

// file: src/aiss_fifo.sv
`timescale 1ns/1ps
module aiss_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ff;
   logic [AW:0] rd_ff;
   logic push;
   logic pop;

   assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign out_data = mem[rd_ff[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= rd_ff + 1'b1;
         end
      end
   end
endmodule

// file: verif/aiss_top_assertions.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module aiss_checker
   import aiss_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // i2c pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // modulator samples
   input wire aiss_sample_t sample_data,
   input wire logic sample_valid,
   input wire logic sample_ready,
   // status
   input wire logic [1:0] mode,
   input wire logic slow_rate_select,
   input wire logic calib_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // two high samples in a row: scl is settled high
   sequence scl_high_run;
      scl_in [*2];
   endsequence
   sequence slow_convert_run;
      (mode == AISS_CONVERT && slow_rate_select) [*3];
   endsequence
   drive_low_a: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   data_quiet_a: assert property (scl_high_run |-> $stable(sda_oe))
      else $error("sda moved while scl high");
   convert_quiet_a: assert property (mode == AISS_CONVERT && $past(mode) == AISS_CONVERT |-> !sda_oe)
      else $error("sda pulled during conversion");
   no_io_a: assert property (mode == AISS_CONVERT |=> mode != AISS_IO)
      else $error("transfer accepted while converting");
   sleep_exit_a: assert property (mode == AISS_SLEEP |=> mode inside {AISS_SLEEP, AISS_IO})
      else $error("sleep left without transfer");
   rate_hold_a: assert property (mode == AISS_SLEEP |=> $stable(slow_rate_select))
      else $error("rate changed in sleep");
   calib_on_a: assert property (slow_convert_run |-> calib_active)
      else $error("no calibration at slow rate");
   calib_off_a: assert property (!slow_rate_select |-> !calib_active)
      else $error("calibration at fast rate");
endmodule
bind aiss_top aiss_checker u_chk (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
   .mode(mode), .slow_rate_select(slow_rate_select), .calib_active(calib_active));

// file: verif/aiss_i2c_master.sv
`timescale 1ns/1ps
// ==========================================
// bus master model: scl period 80 ns, stands high between frames
module aiss_i2c_master (
   // bus
   output logic scl,
   output logic pull,
   input wire logic sda,
   // read result
   output logic rd_done,
   output logic [15:0] rd_data
);
   initial begin
      scl = 1'b1;
      pull = 1'b0;
      rd_done = 1'b0;
      rd_data = 16'h0000;
   end
   // data moves mid-low only, sampled mid-high
   task automatic clk_bit(input logic b, output logic got);
      pull = !b;
      #20 scl = 1'b1;
      #20 got = sda;
      #20 scl = 1'b0;
      #20;
   endtask
   // serves as repeated start too
   task automatic start();
      pull = 1'b0;
      #20 scl = 1'b1;
      #20 pull = 1'b1;
      #40 scl = 1'b0;
      #20;
   endtask
   task automatic stop();
      pull = 1'b1;
      #20 scl = 1'b1;
      #20 pull = 1'b0;
      #40;
   endtask
   task automatic send(input logic [7:0] tx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], s);
      clk_bit(1'b1, s);
      ack = !s;
   endtask
   task automatic read16();
      logic [15:0] r;
      for (int i = 15; i >= 0; i--) clk_bit(1'b1, r[i]);
      rd_data = r;
      rd_done = 1'b1;
      #1 rd_done = 1'b0;
   endtask
endmodule

// file: verif/aiss_testbench.sv
`timescale 1ns/1ps
// ==========================================
// testbench
module testbench
   import aiss_pkg::*;
;
   logic clk, rst, sample_valid, sample_ready, sda_out, sda_oe, slow_rate_select, calib_active;
   logic scl, pull, ack, rd_done, exp_rate;
   logic [1:0] mode;
   logic [15:0] rd_data, cur_exp;
   logic [15:0] exp_q[$];
   aiss_sample_t sample_data, next_sample;
   int bad_count, n_compared, seed;
   // pull-up wins when every party releases
   wire logic sda = !(sda_oe || pull);
   aiss_top #(.POR_CYCLES(50), .CONV60_CYCLES(200), .CONV30_CYCLES(400)) DUT (.clk(clk), .rst(rst),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sample_data(sample_data),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .mode(mode),
      .slow_rate_select(slow_rate_select), .calib_active(calib_active));
   aiss_i2c_master M (.scl(scl), .pull(pull), .sda(sda), .rd_done(rd_done), .rd_data(rd_data));
   always #4 clk = ~clk;
   always @(posedge clk) begin
      sample_valid <= ($random(seed) % 2) != 0;
      sample_data <= next_sample;
   end
   // ==========================================
   // checking
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   always @(posedge rd_done) check(rd_data, exp_q.pop_front());
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #600000;
      bad_count++;
      $display("Error %0t: run hung", $time);
      summarize();
   end
   // ==========================================
   // stimulus helpers
   task automatic set_sample(input logic [1:0] f);
      next_sample = {f, 16'($random(seed))};
      cur_exp = f[1] ? AISS_CODE_MAX : f[0] ? AISS_CODE_MIN : next_sample.code;
   endtask
   task automatic wait_mode(input aiss_mode_t m);
      int n = 0;
      while (mode !== m && n < 5000) begin
         @(posedge clk);
         n++;
      end
      if (mode !== m) begin
         bad_count++;
         $display("Error %0t: mode wait ran out", $time);
         summarize();
      end
   endtask
   task automatic addr(input logic [7:0] b, input logic exp_ack);
      M.start();
      M.send(b, ack);
      check(ack, exp_ack);
   endtask
   task automatic rd();
      addr({AISS_DEV_ADDR, 1'b1}, 1'b1);
      exp_q.push_back(cur_exp);
      M.read16();
   endtask
   // ==========================================
   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      sample_valid = 1'b0;
      sample_data = '0;
      seed = 20;
      bad_count = 0;
      n_compared = 0;
      exp_rate = 1'b0;
      set_sample(2'b00);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (60) @(posedge clk);
      check(mode, AISS_CONVERT);
      addr({AISS_DEV_ADDR, 1'b1}, 1'b0);
      M.stop();
      $display("busy test done");
      for (int k = 0; k < 4; k++) begin
         wait_mode(AISS_SLEEP);
         check(slow_rate_select, exp_rate);
         case (k)
            0: rd();
            1: begin
               addr({AISS_DEV_ADDR ^ 7'h01, 1'b1}, 1'b0);
               M.send(8'h00, ack);
               check(ack, 1'b0);
               M.stop();
               check(mode, AISS_SLEEP);
               addr({AISS_DEV_ADDR, 1'b0}, 1'b1);
               M.send(8'h01, ack);
               check(ack, 1'b1);
               M.send(8'h00, ack);
               check(ack, 1'b0);
               rd();
               exp_rate = 1'b1;
            end
            2: begin
               addr({AISS_GLOBAL_ADDR, 1'b0}, 1'b1);
               M.send(8'h00, ack);
               check(ack, 1'b1);
               exp_rate = 1'b0;
            end
            default: begin
               // long sleep fills the sample buffer until it refuses
               repeat (300) @(posedge clk);
               check(sample_ready, 1'b0);
               rd();
            end
         endcase
         M.stop();
         set_sample(k == 0 ? 2'b10 : k == 2 ? 2'b01 : 2'b00);
         repeat (20) @(posedge clk);
         check(mode, AISS_CONVERT);
         check(calib_active, exp_rate);
         check(slow_rate_select, exp_rate);
         $display("round %0d done", k);
      end
      summarize();
   end
endmodule
